// *** inc/btm_pkg.sv ***
// Shared constants for the built-in-test stimulus and level monitor
package btm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and serial link
  localparam int CLK_HZ     = 125_000_000;
  localparam int BAUD       = 115_200;
  localparam int BIT_CYC    = CLK_HZ / BAUD;
  localparam int HB_MS      = 500;
  localparam int HB_CYC     = (CLK_HZ / 1000) * HB_MS;
  localparam int MON_US     = 1000;
  localparam int MON_CYC    = (CLK_HZ / 1_000_000) * MON_US;

  ////////////////////////////////////////////////////////////////////////////
  // Modulation buffer
  localparam int SAMPLE_BITS = 2;
  localparam int BUF_DEPTH   = 64;
  localparam int NUM_PAT     = 7;
  localparam logic [2:0] USER_PAT = 3'h6;
  localparam int MOD_DIV     = 62;

  ////////////////////////////////////////////////////////////////////////////
  // Converter
  localparam int ADC_BITS     = 12;
  localparam int ADC_CH       = 8;
  localparam int ADC_USED     = 5;
  localparam int ADC_FULL_MV  = 5000;
  localparam int ADC_LSB_UV   = 1220;
  localparam logic [2:0] CH_RF   = 3'h0;
  localparam logic [2:0] CH_TEMP = 3'h1;
  localparam logic [2:0] CH_P15  = 3'h2;
  localparam logic [2:0] CH_P5   = 3'h3;
  localparam logic [2:0] CH_M5   = 3'h4;
  localparam logic [11:0] TEMP_LO = 12'h199;
  localparam logic [11:0] TEMP_HI = 12'h666;
  localparam logic [11:0] SUP_LO  = 12'h99a;
  localparam logic [11:0] SUP_HI  = 12'ha66;
  localparam int PHASE_DB         = 20;
  localparam int LOGAMP_UV_PER_DB = 25_000;
  localparam int PHASE_MIN_CODES  = PHASE_DB * LOGAMP_UV_PER_DB / ADC_LSB_UV;

  ////////////////////////////////////////////////////////////////////////////
  // Command opcodes
  localparam logic [7:0] OP_LOAD  = 8'h01;
  localparam logic [7:0] OP_USER  = 8'h02;
  localparam logic [7:0] OP_START = 8'h03;
  localparam logic [7:0] OP_RFSEL = 8'h04;
  localparam logic [7:0] OP_CONV  = 8'h05;
  localparam logic [7:0] OP_STAT  = 8'h06;

  typedef enum logic [1:0] {RF_SUM, RF_DIFF, RF_OMNI, RF_COMB} btm_rf_type;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_PLAY} btm_seq_type;

endpackage : btm_pkg

// *** design/btm_uart_rx.sv ***
// Serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
module btm_uart_rx #(
  parameter int BIT_CYC = btm_pkg::BIT_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       rxd_in,
  output logic [7:0]      data_out,
  output logic            valid_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    btm_rx_st_type;
  typedef struct packed {
    btm_rx_st_type st;
    logic [15:0]   cnt;
    logic [2:0]    n;
    logic [7:0]    sh;
    logic          valid;
  } btm_rx_type;

  btm_rx_type q, d;

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.cnt = q.cnt + 16'h0001;
    case (q.st)
      RX_IDLE: begin
        d.cnt = '0;
        if (!rxd_in) d.st = RX_START;
      end
      RX_START: begin
        if (q.cnt == 16'(BIT_CYC / 2 - 1)) begin
          d.cnt = '0;
          d.n = '0;
          d.st = rxd_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (q.cnt == 16'(BIT_CYC - 1)) begin
          d.cnt = '0;
          d.sh = {rxd_in, q.sh[7:1]};
          d.n = q.n + 3'h1;
          if (q.n == 3'h7) d.st = RX_STOP;
        end
      end
      default: begin
        if (q.cnt == 16'(BIT_CYC - 1)) begin
          d.st = RX_IDLE;
          d.valid = rxd_in;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign data_out  = q.sh;
  assign valid_out = q.valid;
endmodule : btm_uart_rx
`default_nettype wire

// *** design/btm_uart_tx.sv ***
// Serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
module btm_uart_tx #(
  parameter int BIT_CYC = btm_pkg::BIT_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] data_in,
  input  wire logic       valid_in,
  output logic            ready_out,
  output logic            txd_out
);
  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic [3:0]  n;
    logic [9:0]  sh;
    logic        idle_n;
  } btm_tx_type;

  btm_tx_type q, d;

  always_comb begin
    d = q;
    if (!q.busy) begin
      if (valid_in) begin
        d.busy = 1'b1;
        d.sh = {1'b1, data_in, 1'b0};
        d.cnt = '0;
        d.n = '0;
        d.idle_n = 1'b1;
      end
    end else if (q.cnt == 16'(BIT_CYC - 1)) begin
      d.cnt = '0;
      d.sh = {1'b1, q.sh[9:1]};
      d.n = q.n + 4'h1;
      if (q.n == 4'h9) begin
        d.busy = 1'b0;
        d.idle_n = 1'b0;
      end
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign ready_out = !q.busy;
  assign txd_out   = q.idle_n ? q.sh[0] : 1'b1;
endmodule : btm_uart_tx
`default_nettype wire

// *** design/btm_bit_ctrl.sv ***
// Built-in-test sequencer, level measurement control and command slave
`timescale 1ns/1ps
`default_nettype none
module btm_bit_ctrl #(
  parameter int DEPTH   = btm_pkg::BUF_DEPTH,
  parameter int MOD_DIV = btm_pkg::MOD_DIV,
  parameter int MON_CYC = btm_pkg::MON_CYC,
  parameter int HB_CYC  = btm_pkg::HB_CYC,
  parameter int BIT_CYC = btm_pkg::BIT_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        host_rxd_in,
  output logic             host_txd_out,
  output logic             pulse_gate_bit_out,
  output logic             phase_bit_out,
  output logic [1:0]       rf_sel_out,
  output logic [2:0]       adc_ch_out,
  output logic             adc_start_out,
  input  wire logic        adc_done_in,
  input  wire logic [11:0] adc_data_in,
  input  wire logic        synth_lock_in,
  output logic             led_supply_ok_out,
  output logic             led_temp_ok_out,
  output logic             led_lock_ok_out,
  output logic             led_proc_ok_out,
  output logic             seq_busy_out
);
  localparam int IW = $clog2(DEPTH);

  typedef struct packed {
    btm_pkg::btm_seq_type st;
    logic [2:0]             pat;
    logic [IW:0]            idx;
    logic [15:0]            div;
    logic [DEPTH-1:0][1:0]  buff;
    logic [DEPTH-1:0][1:0]  user;
    logic [IW-1:0]          uptr;
    logic                   loaded;
    logic                   gate;
    logic                   phase;
    logic                   have_op;
    logic [7:0]             op;
    btm_pkg::btm_rf_type    rf;
    logic                   hpend;
    logic [2:0]             hch;
    logic                   href;
    logic                   adc_busy;
    logic                   adc_host;
    logic                   adc_ref;
    logic [2:0]             adc_ch;
    logic                   adc_start;
    logic [2:0]             mch;
    logic [23:0]            mtmr;
    logic                   mreq;
    logic                   temp_ok;
    logic                   p15_ok;
    logic                   p5_ok;
    logic                   m5_ok;
    logic [11:0]            ref_lvl;
    logic                   phase_pass;
    logic [1:0]             tx_cnt;
    logic [7:0]             tx_b0;
    logic [7:0]             tx_b1;
    logic [27:0]            hb_tmr;
    logic                   hb;
  } btm_state_type;

  btm_state_type q, d;
  logic [7:0]    rx_data;
  logic          rx_valid;
  logic          tx_ready;
  logic          tick;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [1:0] pat_sample(input logic [2:0] p,
                                            input logic [IW:0] i);
    logic [IW:0] sp;
    logic        g;
    logic        ph;
    sp = (IW+1)'({p, 2'b00}) + (IW+1)'(8);
    g  = (i < (IW+1)'(2)) || (i >= sp && i < sp + (IW+1)'(2));
    ph = (p >= 3'h4) && (i >= sp) && i[0];
    return {ph, g};
  endfunction : pat_sample

  function automatic logic [11:0] absdiff(input logic [11:0] a,
                                          input logic [11:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic logic mon_ok(input logic [2:0] ch,
                                  input logic [11:0] c);
    if (ch == btm_pkg::CH_TEMP)
      return c >= btm_pkg::TEMP_LO && c <= btm_pkg::TEMP_HI;
    return c >= btm_pkg::SUP_LO && c <= btm_pkg::SUP_HI;
  endfunction : mon_ok

  ////////////////////////////////////////////////////////////////////////////
  // Serial command port
  btm_uart_rx #(.BIT_CYC(BIT_CYC)) u_btm_uart_rx (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .rxd_in    (host_rxd_in),
    .data_out  (rx_data),
    .valid_out (rx_valid)
  );

  btm_uart_tx #(.BIT_CYC(BIT_CYC)) u_btm_uart_tx (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .data_in   (q.tx_b0),
    .valid_in  (q.tx_cnt != 2'h0),
    .ready_out (tx_ready),
    .txd_out   (host_txd_out)
  );

  assign tick = (q.div == 16'(MOD_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.adc_start = 1'b0;
    // Reply drain
    if (q.tx_cnt != 2'h0 && tx_ready) begin
      d.tx_b0 = q.tx_b1;
      d.tx_cnt = q.tx_cnt - 2'h1;
    end
    // Commands: decoded only when a host byte arrives
    if (rx_valid && !q.have_op) begin
      case (rx_data)
        btm_pkg::OP_START: begin
          if (q.st == btm_pkg::SEQ_IDLE && q.loaded) begin
            d.st = btm_pkg::SEQ_PLAY;
            d.idx = '0;
            d.div = '0;
          end
        end
        btm_pkg::OP_STAT: begin
          if (q.tx_cnt == 2'h0) begin
            d.tx_b0 = {q.phase_pass, synth_lock_in, q.temp_ok, q.p15_ok,
                       q.p5_ok, q.m5_ok, seq_busy_out, q.loaded};
            d.tx_cnt = 2'h1;
          end
        end
        btm_pkg::OP_LOAD, btm_pkg::OP_USER, btm_pkg::OP_RFSEL,
        btm_pkg::OP_CONV: begin
          d.have_op = 1'b1;
          d.op = rx_data;
        end
        default: ;
      endcase
    end else if (rx_valid) begin
      d.have_op = 1'b0;
      case (q.op)
        btm_pkg::OP_LOAD: begin
          if (q.st == btm_pkg::SEQ_IDLE && rx_data[7:3] == 5'h00 &&
              rx_data[2:0] < 3'(btm_pkg::NUM_PAT)) begin
            d.st = btm_pkg::SEQ_LOAD;
            d.pat = rx_data[2:0];
            d.idx = '0;
            d.loaded = 1'b0;
          end
        end
        btm_pkg::OP_USER: begin
          if (rx_data[7]) begin
            d.uptr = '0;
          end else begin
            d.user[q.uptr] = rx_data[1:0];
            d.uptr = q.uptr + IW'(1);
          end
        end
        btm_pkg::OP_RFSEL: d.rf = btm_pkg::btm_rf_type'(rx_data[1:0]);
        btm_pkg::OP_CONV: begin
          if (!q.hpend) begin
            d.hpend = 1'b1;
            d.hch = rx_data[2:0];
            d.href = rx_data[7];
          end
        end
        default: ;
      endcase
    end
    // Sequencer
    case (q.st)
      btm_pkg::SEQ_LOAD: begin
        d.buff[q.idx[IW-1:0]] = (q.pat == btm_pkg::USER_PAT) ?
          q.user[q.idx[IW-1:0]] : pat_sample(q.pat, q.idx);
        d.idx = q.idx + (IW+1)'(1);
        if (q.idx == (IW+1)'(DEPTH - 1)) begin
          d.st = btm_pkg::SEQ_IDLE;
          d.loaded = 1'b1;
        end
      end
      btm_pkg::SEQ_PLAY: begin
        d.div = tick ? 16'h0000 : q.div + 16'h0001;
        if (tick) begin
          if (q.idx == (IW+1)'(DEPTH)) begin
            d.gate = 1'b0;
            d.phase = 1'b0;
            d.st = btm_pkg::SEQ_IDLE;
          end else begin
            d.gate = q.buff[q.idx[IW-1:0]][0];
            d.phase = q.buff[q.idx[IW-1:0]][1];
            d.idx = q.idx + (IW+1)'(1);
          end
        end
      end
      default: ;
    endcase
    // Background monitor timer
    if (q.mtmr == 24'(MON_CYC - 1)) begin
      d.mtmr = '0;
      d.mreq = 1'b1;
    end else begin
      d.mtmr = q.mtmr + 24'h000001;
    end
    // Converter control
    if (!q.adc_busy) begin
      if (q.hpend) begin
        d.hpend = 1'b0;
        d.adc_busy = 1'b1;
        d.adc_host = 1'b1;
        d.adc_ref = q.href;
        d.adc_ch = q.hch;
        d.adc_start = 1'b1;
      end else if (q.mreq) begin
        d.mreq = (q.mtmr == 24'(MON_CYC - 1));
        d.adc_busy = 1'b1;
        d.adc_host = 1'b0;
        d.adc_ch = q.mch;
        d.adc_start = 1'b1;
      end
    end else if (adc_done_in) begin
      d.adc_busy = 1'b0;
      if (q.adc_host) begin
        if (q.tx_cnt == 2'h0) begin
          d.tx_b0 = {4'h0, adc_data_in[11:8]};
          d.tx_b1 = adc_data_in[7:0];
          d.tx_cnt = 2'h2;
        end
        if (q.adc_ref) begin
          d.ref_lvl = adc_data_in;
        end else if (q.adc_ch == btm_pkg::CH_RF &&
                     q.rf == btm_pkg::RF_COMB) begin
          d.phase_pass = absdiff(adc_data_in, q.ref_lvl) >=
                         12'(btm_pkg::PHASE_MIN_CODES);
        end
      end else begin
        case (q.adc_ch)
          btm_pkg::CH_TEMP: d.temp_ok = mon_ok(q.adc_ch, adc_data_in);
          btm_pkg::CH_P15:  d.p15_ok = mon_ok(q.adc_ch, adc_data_in);
          btm_pkg::CH_P5:   d.p5_ok = mon_ok(q.adc_ch, adc_data_in);
          btm_pkg::CH_M5:   d.m5_ok = mon_ok(q.adc_ch, adc_data_in);
          default: ;
        endcase
        d.mch = (q.mch == btm_pkg::CH_M5) ? btm_pkg::CH_TEMP :
                q.mch + 3'h1;
      end
    end
    // Processor heartbeat
    if (q.hb_tmr == 28'(HB_CYC - 1)) begin
      d.hb_tmr = '0;
      d.hb = !q.hb;
    end else begin
      d.hb_tmr = q.hb_tmr + 28'h0000001;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pulse_gate_bit_out = q.gate;
  assign phase_bit_out      = q.phase;
  assign rf_sel_out         = q.rf;
  assign adc_ch_out         = q.adc_ch;
  assign adc_start_out      = q.adc_start;
  assign led_supply_ok_out  = q.p15_ok && q.p5_ok && q.m5_ok;
  assign led_temp_ok_out    = q.temp_ok;
  assign led_lock_ok_out    = synth_lock_in;
  assign led_proc_ok_out    = q.hb;
  assign seq_busy_out       = q.st != btm_pkg::SEQ_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gate_idle;
    @(posedge mclk_in) disable iff (rst_in)
      q.st != btm_pkg::SEQ_PLAY |-> !pulse_gate_bit_out && !phase_bit_out;
  endproperty
  a_gate_idle: assert property (p_gate_idle)
    else $error("gate active outside playback");

  property p_last_sample;
    @(posedge mclk_in) disable iff (rst_in)
      q.st == btm_pkg::SEQ_PLAY && q.idx == (IW+1)'(DEPTH) && tick
      |=> q.st == btm_pkg::SEQ_IDLE && !pulse_gate_bit_out;
  endproperty
  a_last_sample: assert property (p_last_sample)
    else $error("sequencer did not stop after last sample");

  property p_one_shot;
    @(posedge mclk_in) disable iff (rst_in)
      q.st == btm_pkg::SEQ_IDLE &&
      !(rx_valid && !q.have_op && rx_data == btm_pkg::OP_START)
      |=> q.st != btm_pkg::SEQ_PLAY;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("playback began without a start command");

  property p_no_restart;
    @(posedge mclk_in) disable iff (rst_in)
      q.st == btm_pkg::SEQ_PLAY |=> q.idx >= $past(q.idx);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("running sequence was restarted");

  property p_sample_rate;
    @(posedge mclk_in) disable iff (rst_in)
      q.st == btm_pkg::SEQ_PLAY && !tick
      |=> $stable(q.idx) && $stable(pulse_gate_bit_out);
  endproperty
  a_sample_rate: assert property (p_sample_rate)
    else $error("sample advanced between modulation ticks");

  property p_adc_cmd;
    @(posedge mclk_in) disable iff (rst_in)
      adc_start_out |-> q.adc_busy && !$past(q.adc_busy);
  endproperty
  a_adc_cmd: assert property (p_adc_cmd)
    else $error("conversion start while converter busy");

  property p_rfsel;
    @(posedge mclk_in) disable iff (rst_in)
      rx_valid && q.have_op && q.op == btm_pkg::OP_RFSEL
      |=> rf_sel_out == $past(rx_data[1:0]);
  endproperty
  a_rfsel: assert property (p_rfsel)
    else $error("input select did not follow command");

  property p_reply_req;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(q.tx_cnt != 2'h0)
      |-> $past(rx_valid) || $past(adc_done_in && q.adc_host);
  endproperty
  a_reply_req: assert property (p_reply_req)
    else $error("unsolicited reply");

  property p_phase;
    @(posedge mclk_in) disable iff (rst_in)
      adc_done_in && q.adc_busy && q.adc_host && !q.adc_ref &&
      q.adc_ch == btm_pkg::CH_RF && q.rf == btm_pkg::RF_COMB
      |=> q.phase_pass == (absdiff($past(adc_data_in), $past(q.ref_lvl))
                           >= 12'(btm_pkg::PHASE_MIN_CODES));
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase swing verdict wrong");
endmodule : btm_bit_ctrl
`default_nettype wire

// *** testbench/btm_host_model.sv ***
// Host controller and converter model facing the test logic
`timescale 1ns/1ps
`default_nettype none
module btm_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       mclk_in,
  input  wire logic       host_txd_in,
  output logic            host_rxd_out,
  input  wire logic       adc_start_in,
  input  wire logic [2:0] adc_ch_in,
  output logic            adc_done_out,
  output logic [11:0]     adc_data_out
);
  logic [11:0] level [0:7];
  logic [11:0] held_q;
  int          wait_q;
  initial begin
    host_rxd_out = 1'b1;
    adc_done_out = 1'b0;
    adc_data_out = 12'h000;
    held_q = 12'h000;
    wait_q = 0;
    for (int i = 0; i < 8; i++) begin
      level[i] = 12'h9f0 + 12'(i * 16);
    end
    level[1] = 12'h400;
  end
  //////////////////////////////////////////
  // Host starts every byte, 8N1 at logic level
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge mclk_in);
    for (int i = 0; i < 10; i++) begin
      host_rxd_out <= f[i];
      repeat (BIT_CYC) @(posedge mclk_in);
    end
    #1;
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (host_txd_in !== 1'b0 && n < 40 * BIT_CYC) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (host_txd_in === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge mclk_in);
      #1;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk_in);
        #1;
        b[i] = host_txd_in;
      end
      repeat (BIT_CYC) @(posedge mclk_in);
      #1;
      ok = (host_txd_in === 1'b1);
    end
  endtask : recv_byte
  //////////////////////////////////////////
  // Converter answers six cycles after start
  always @(posedge mclk_in) begin
    if (adc_start_in === 1'b1) begin
      held_q <= level[adc_ch_in];
      wait_q <= 6;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 1) begin
      adc_done_out <= 1'b1;
      adc_data_out <= held_q;
      wait_q <= 0;
    end else begin
      adc_done_out <= 1'b0;
      adc_data_out <= ~held_q;
    end
  end
endmodule : btm_host_model
`default_nettype wire

// *** testbench/tb_btm_bit_ctrl.sv ***
// Testbench for the built-in-test control block
`timescale 1ns/1ps
`default_nettype none
module tb_btm_bit_ctrl;
  localparam int BC = 16;
  localparam int MD = 8;
  localparam int DP = 64;
  localparam int HB = 100;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        lock = 1'b1;
  logic        rxd, txd, gate, phs, start, done, busy;
  logic        led_s, led_t, led_l, led_p;
  logic [1:0]  rsel;
  logic [2:0]  ch;
  logic [11:0] dat;
  int          num_errors = 0;
  int          comparisons = 0;
  always #4 mclk_in = ~mclk_in;
  btm_bit_ctrl #(.DEPTH(DP), .MOD_DIV(MD), .MON_CYC(200), .HB_CYC(HB),
    .BIT_CYC(BC)) u_btm_bit_ctrl (.mclk_in(mclk_in), .rst_in(rst_in),
    .host_rxd_in(rxd), .host_txd_out(txd), .pulse_gate_bit_out(gate),
    .phase_bit_out(phs), .rf_sel_out(rsel), .adc_ch_out(ch),
    .adc_start_out(start), .adc_done_in(done), .adc_data_in(dat),
    .synth_lock_in(lock), .led_supply_ok_out(led_s),
    .led_temp_ok_out(led_t), .led_lock_ok_out(led_l),
    .led_proc_ok_out(led_p), .seq_busy_out(busy));
  btm_host_model #(.BIT_CYC(BC)) u_btm_host_model (.mclk_in(mclk_in),
    .host_txd_in(txd), .host_rxd_out(rxd), .adc_start_in(start),
    .adc_ch_in(ch), .adc_done_out(done), .adc_data_out(dat));
  //////////////////////////////////////////
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic snd(input logic [7:0] b);
    u_btm_host_model.send_byte(b);
  endtask : snd
  task automatic get(output logic [7:0] b);
    logic ok;
    u_btm_host_model.recv_byte(b, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask : get
  task automatic stat(input logic [7:0] e);
    logic [7:0] b;
    snd(btm_pkg::OP_STAT);
    get(b);
    check(16'(b), 16'(e));
  endtask : stat
  task automatic conv(input logic [7:0] c, input logic [11:0] e);
    logic [7:0] h, l;
    snd(btm_pkg::OP_CONV);
    snd(c);
    get(h);
    get(l);
    check({h, l}, {4'h0, e});
  endtask : conv
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    check(16'(busy), 16'h0);
    if (n >= 500) complete_run();
  endtask : wait_idle
  //////////////////////////////////////////
  task automatic t_mon();
    int n;
    logic p;
    check(16'({txd, busy, gate, rsel}), 16'h10);
    n = 0;
    repeat (1500) begin
      tick(1);
      if (txd !== 1'b1 || busy !== 1'b0) n++;
    end
    check(16'(n), 16'h0);
    check(16'({led_t, led_s, led_l}), 16'h7);
    @(posedge mclk_in) lock <= 1'b0;
    tick(2);
    check(16'(led_l), 16'h0);
    @(posedge mclk_in) lock <= 1'b1;
    repeat (2) begin
      p = led_p;
      n = 0;
      while (led_p === p && n < 2 * HB) begin
        tick(1);
        n++;
      end
      if (n >= 2 * HB) begin
        num_errors++;
        complete_run();
      end
    end
    check(16'(n), 16'(HB));
  endtask : t_mon
  task automatic t_load();
    stat(8'h7c);
    snd(btm_pkg::OP_START);
    tick(4);
    check(16'(busy), 16'h0);
    snd(btm_pkg::OP_LOAD);
    snd(8'h07);
    tick(4);
    check(16'(busy), 16'h0);
    for (int p = 0; p < 6; p++) begin
      snd(btm_pkg::OP_LOAD);
      snd(8'(p));
      check(16'(busy), 16'h1);
      wait_idle();
    end
    stat(8'h7d);
  endtask : t_load
  task automatic t_play();
    int k, cyc, last;
    logic [1:0] cur, prev;
    snd(btm_pkg::OP_USER);
    snd(8'h80);
    for (int i = 0; i < DP; i++) begin
      snd(btm_pkg::OP_USER);
      snd(8'(i % 3 + 1));
    end
    snd(btm_pkg::OP_LOAD);
    snd({5'h00, btm_pkg::USER_PAT});
    wait_idle();
    k = 0;
    cyc = 0;
    last = 0;
    prev = 2'b00;
    fork
      begin
        snd(btm_pkg::OP_START);
        tick(MD * 10);
        snd(btm_pkg::OP_START);
      end
      while (k < DP + 1 && cyc < 10 * BC + (DP + 4) * MD) begin
        tick(1);
        cyc++;
        cur = {phs, gate};
        if (cur !== prev) begin
          if (k > 0) check(16'(cyc - last), 16'(MD));
          check(16'(cur), (k < DP) ? 16'(k % 3 + 1) : 16'h0);
          if (k == DP) check(16'(busy), 16'h0);
          prev = cur;
          last = cyc;
          k++;
        end
      end
    join
    check(16'(k), 16'(DP + 1));
    if (k != DP + 1) complete_run();
    tick(200);
    check(16'(busy), 16'h0);
  endtask : t_play
  task automatic t_rf();
    for (int s = 0; s < 4; s++) begin
      snd(btm_pkg::OP_RFSEL);
      snd(8'(s));
      tick(2);
      check(16'(rsel), 16'(s));
    end
    u_btm_host_model.level[0] = 12'h100;
    conv(8'h80, 12'h100);
    u_btm_host_model.level[0] = 12'h298;
    conv(8'h00, 12'h298);
    stat(8'h7d);
    u_btm_host_model.level[0] = 12'h299;
    conv(8'h00, 12'h299);
    stat(8'hfd);
  endtask : t_rf
  //////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    tick(2);
    t_mon();
    t_load();
    t_play();
    for (int c = 0; c < 5; c++) begin
      conv(8'(c), u_btm_host_model.level[c]);
    end
    t_rf();
    complete_run();
  end
endmodule : tb_btm_bit_ctrl
`default_nettype wire
